// ### adc_diag_defs.vh
// Register offsets, field positions, reset values and codes for the diagnostic comparison block.
`ifndef ADC_DIAG_DEFS_VH
`define ADC_DIAG_DEFS_VH

// Printed offsets are not all multiples of four, so they are indices; byte address is index * 4.
`define ADG_IDX_CELL_THR      12'h33A
`define ADG_IDX_AUX_OPEN_WIRE_LIMIT    12'h33B
`define ADG_IDX_CMP_CTRL      12'h33C
`define ADG_IDX_INJ_CTRL      12'h33D
`define ADG_IDX_PROT_CTRL     12'h33E
`define ADG_IDX_SW_SEL        12'h339
`define ADG_IDX_STATUS        12'h340
`define ADG_IDX_BAL_CTRL      12'h341
`define ADG_IDX_CELL_SEL      12'h342

`define ADG_RST_BYTE          8'h00

// Field positions.
`define ADG_F_CELL_THR_MSB    4
`define ADG_F_OPEN_WIRE_LIMIT_MSB      3
`define ADG_F_AUX_THR_LSB     4
`define ADG_F_AUX_THR_MSB     6
`define ADG_F_SEL_LSB         1
`define ADG_F_SEL_MSB         3
`define ADG_F_SINK_LSB        4
`define ADG_F_SINK_MSB        5
`define ADG_F_GO              0
`define ADG_F_SW_GO           6
`define ADG_F_FILT_INJ        0
`define ADG_F_CMP_INJ         1
`define ADG_F_KEEP_FAULT      0

// Comparison selection codes.
`define ADG_SEL_NONE          3'h0
`define ADG_SEL_CELL          3'h1
`define ADG_SEL_SENSE_OW      3'h2
`define ADG_SEL_BAL_OW        3'h3
`define ADG_SEL_SWITCH        3'h4
`define ADG_SEL_AUX_IN        3'h5

// Sink select codes.
`define ADG_SINK_OFF          2'h0
`define ADG_SINK_SENSE        2'h1
`define ADG_SINK_BAL          2'h2
`define ADG_SINK_SHUNT        2'h3

// Threshold scaling in millivolts.
`define ADG_CELL_BASE_MV      16'h0006
`define ADG_CELL_STEP_MV      16'h0003
`define ADG_CELL_MAX_MV       16'h0063
`define ADG_AUX_BASE_MV       16'h0004
`define ADG_AUX_STEP_MV       16'h0004
`define ADG_OW_BASE_MV        16'h01F4
`define ADG_OW_STEP_MV        16'h012C
`define ADG_OW_MAX_MV         16'h1388

`endif

// ### adg_diag_compare.v
// Diagnostic comparison controller with APB register slave.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "adc_diag_defs.vh"

module adg_diag_compare #(
  parameter N_CH = 6,
  parameter MW   = 16
) (
  input  wire                clock,
  input  wire                nrst,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [13:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire [N_CH*MW-1:0]  main_mv,
  input  wire [N_CH*MW-1:0]  aux_mv,
  input  wire [N_CH-1:0]     active_cell,
  input  wire [N_CH-1:0]     aux_is_analog,
  input  wire                balancing_run,
  input  wire                balancing_start,
  input  wire [N_CH-1:0]     regular_switch,
  input  wire                filter_test_fault,
  input  wire                selftest_channel_step,
  input  wire [3:0]          selftest_fault_in,
  output reg  [N_CH-1:0]     balancing_switch,
  output reg                 sense_sink_en,
  output reg                 balance_sink_en,
  output reg                 shunt_source_en,
  output reg                 compare_busy,
  output reg  [3:0]          selftest_fault_q,
  output reg                 fault_pin_n
);

  reg  [7:0]      cell_thr_q;
  reg  [7:0]      aux_ow_q;
  reg  [7:0]      ctrl_q;
  reg  [7:0]      inj_q;
  reg  [7:0]      prot_q;
  reg  [7:0]      sw_sel_q;
  reg  [7:0]      cell_sel_q;
  reg             switch_hold_option_q;
  reg  [2:0]      sel_q;
  reg             go_q;
  reg             override_q;
  reg  [N_CH-1:0] override_mask_q;
  reg  [N_CH-1:0] test_mask_q;
  reg             cell_check_ready_q;
  reg             sense_pin_open_ready_q;
  reg             balance_pin_open_ready_q;
  reg             switch_check_ready_q;
  reg             aux_input_check_ready_q;
  reg             pass_q;
  reg             filter_failure_flag_q;
  reg             fault_latch_q;

  wire [11:0] idx = paddr[13:2];
  wire        wr  = psel & penable & pwrite;
  wire        rd  = psel & penable & ~pwrite;
  wire        mapped = (idx == `ADG_IDX_CELL_THR) || (idx == `ADG_IDX_AUX_OPEN_WIRE_LIMIT) ||
                       (idx == `ADG_IDX_CMP_CTRL) || (idx == `ADG_IDX_INJ_CTRL) ||
                       (idx == `ADG_IDX_PROT_CTRL) || (idx == `ADG_IDX_SW_SEL) ||
                       (idx == `ADG_IDX_STATUS) || (idx == `ADG_IDX_BAL_CTRL) ||
                       (idx == `ADG_IDX_CELL_SEL);
  wire        go_wr = wr && (idx == `ADG_IDX_CMP_CTRL) && pwdata[`ADG_F_GO];
  wire        sw_go_wr = wr && (idx == `ADG_IDX_CMP_CTRL) && pwdata[`ADG_F_SW_GO];

  // Threshold decode in millivolts.
  wire [MW-1:0] cell_lim_raw = `ADG_CELL_BASE_MV +
                               `ADG_CELL_STEP_MV * {11'h000, cell_thr_q[`ADG_F_CELL_THR_MSB:0]};
  wire [MW-1:0] cell_delta_limit = (cell_lim_raw > `ADG_CELL_MAX_MV) ?
                                   `ADG_CELL_MAX_MV : cell_lim_raw;
  wire [MW-1:0] aux_input_delta_limit = `ADG_AUX_BASE_MV + `ADG_AUX_STEP_MV *
      {13'h0000, aux_ow_q[`ADG_F_AUX_THR_MSB:`ADG_F_AUX_THR_LSB]};
  wire [MW-1:0] ow_raw = `ADG_OW_BASE_MV +
                         `ADG_OW_STEP_MV * {12'h000, aux_ow_q[`ADG_F_OPEN_WIRE_LIMIT_MSB:0]};
  wire [MW-1:0] open_wire_limit = (ow_raw > `ADG_OW_MAX_MV) ? `ADG_OW_MAX_MV : ow_raw;

  // Per-channel checks; a channel not under test always passes.
  wire [N_CH-1:0] ch_ok;
  genvar g;
  generate
    for (g = 0; g < N_CH; g = g + 1) begin : g_ch
      wire [MW-1:0] m = main_mv[g*MW +: MW];
      wire [MW-1:0] a = aux_mv[g*MW +: MW];
      wire [MW-1:0] d = (m > a) ? (m - a) : (a - m);
      reg           ok;
      always @* begin
        case (sel_q)
          `ADG_SEL_CELL:     ok = ~cell_sel_q[g] | (d < cell_delta_limit);
          `ADG_SEL_SENSE_OW: ok = ~active_cell[g] | (m < open_wire_limit);
          `ADG_SEL_BAL_OW:   ok = ~cell_sel_q[g] | (a < open_wire_limit);
          `ADG_SEL_SWITCH:   ok = ~cell_sel_q[g] | ({a, 1'b0} + a < {1'b0, m});
          `ADG_SEL_AUX_IN:   ok = ~aux_is_analog[g] | (d < aux_input_delta_limit);
          default:           ok = 1'b1;
        endcase
      end
      assign ch_ok[g] = ok;
    end
  endgenerate

  wire result_pass = (&ch_ok) & ~inj_q[`ADG_F_CMP_INJ];

  // Comparison start, one evaluation cycle, then ready flag.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_q                    <= `ADG_SEL_NONE;
      go_q                     <= 1'b0;
      compare_busy             <= 1'b0;
      pass_q                   <= 1'b0;
      test_mask_q              <= {N_CH{1'b0}};
      cell_check_ready_q       <= 1'b0;
      sense_pin_open_ready_q   <= 1'b0;
      balance_pin_open_ready_q <= 1'b0;
      switch_check_ready_q     <= 1'b0;
      aux_input_check_ready_q  <= 1'b0;
    end else begin
      if (go_wr) begin
        sel_q        <= pwdata[`ADG_F_SEL_MSB:`ADG_F_SEL_LSB];
        go_q         <= 1'b1;
        compare_busy <= (pwdata[`ADG_F_SEL_MSB:`ADG_F_SEL_LSB] <= `ADG_SEL_AUX_IN) &&
                        (pwdata[`ADG_F_SEL_MSB:`ADG_F_SEL_LSB] != `ADG_SEL_NONE);
        if (pwdata[`ADG_F_SEL_MSB:`ADG_F_SEL_LSB] == `ADG_SEL_SWITCH)
          test_mask_q <= sw_sel_q[N_CH-1:0];
      end else if (rd && idx == `ADG_IDX_CMP_CTRL) begin
        go_q <= 1'b0;
      end
      if (compare_busy && !go_wr) begin
        compare_busy <= 1'b0;
        pass_q       <= result_pass;
        case (sel_q)
          `ADG_SEL_CELL:     cell_check_ready_q       <= 1'b1;
          `ADG_SEL_SENSE_OW: sense_pin_open_ready_q   <= 1'b1;
          `ADG_SEL_BAL_OW:   balance_pin_open_ready_q <= 1'b1;
          `ADG_SEL_SWITCH:   switch_check_ready_q     <= 1'b1;
          `ADG_SEL_AUX_IN:   aux_input_check_ready_q  <= 1'b1;
          default:           pass_q                   <= 1'b0;
        endcase
        if (sel_q == `ADG_SEL_SWITCH && !switch_hold_option_q)
          test_mask_q <= {N_CH{1'b0}};
      end
      if (go_wr) begin
        cell_check_ready_q       <= 1'b0;
        sense_pin_open_ready_q   <= 1'b0;
        balance_pin_open_ready_q <= 1'b0;
        switch_check_ready_q     <= 1'b0;
        aux_input_check_ready_q  <= 1'b0;
      end
      if (balancing_start)
        test_mask_q <= {N_CH{1'b0}};
    end
  end

  // Manual switch override and switch drive.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      override_q       <= 1'b0;
      override_mask_q  <= {N_CH{1'b0}};
      balancing_switch <= {N_CH{1'b0}};
    end else begin
      if (balancing_start)
        override_q <= 1'b0;
      else if (sw_go_wr && !balancing_run) begin
        override_q      <= 1'b1;
        override_mask_q <= sw_sel_q[N_CH-1:0];
      end
      if (balancing_run)
        balancing_switch <= regular_switch;
      else if (override_q)
        balancing_switch <= override_mask_q | test_mask_q;
      else
        balancing_switch <= test_mask_q;
    end
  end

  // Sink control follows the register one clock later.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sense_sink_en   <= 1'b0;
      balance_sink_en <= 1'b0;
      shunt_source_en <= 1'b0;
    end else begin
      sense_sink_en   <= (ctrl_q[`ADG_F_SINK_MSB:`ADG_F_SINK_LSB] == `ADG_SINK_SENSE);
      balance_sink_en <= (ctrl_q[`ADG_F_SINK_MSB:`ADG_F_SINK_LSB] == `ADG_SINK_BAL);
      shunt_source_en <= (ctrl_q[`ADG_F_SINK_MSB:`ADG_F_SINK_LSB] == `ADG_SINK_SHUNT);
    end
  end

  // Filter failure and protector self-test fault handling.
  wire keep = prot_q[`ADG_F_KEEP_FAULT];
  wire stat_wr = wr && (idx == `ADG_IDX_STATUS);
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      filter_failure_flag_q <= 1'b0;
      selftest_fault_q      <= 4'h0;
      fault_latch_q         <= 1'b0;
      fault_pin_n           <= 1'b1;
    end else begin
      // A set in the same cycle as a software clear wins.
      if (filter_test_fault || inj_q[`ADG_F_FILT_INJ])
        filter_failure_flag_q <= 1'b1;
      else if (stat_wr && pwdata[7])
        filter_failure_flag_q <= 1'b0;
      if (selftest_channel_step && !keep) begin
        selftest_fault_q <= selftest_fault_in;
        fault_latch_q    <= 1'b0;
      end else begin
        selftest_fault_q <= selftest_fault_q | selftest_fault_in;
        if (|selftest_fault_in)
          fault_latch_q <= 1'b1;
        else if (stat_wr && pwdata[6] && !keep)
          fault_latch_q <= 1'b0;
      end
      if (stat_wr && pwdata[6] && !(|selftest_fault_in))
        selftest_fault_q <= 4'h0;
      fault_pin_n <= ~(fault_latch_q | (|selftest_fault_in));
    end
  end

  // APB register slave, zero wait states.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cell_thr_q           <= `ADG_RST_BYTE;
      aux_ow_q             <= `ADG_RST_BYTE;
      ctrl_q               <= `ADG_RST_BYTE;
      inj_q                <= `ADG_RST_BYTE;
      prot_q               <= `ADG_RST_BYTE;
      sw_sel_q             <= `ADG_RST_BYTE;
      cell_sel_q           <= `ADG_RST_BYTE;
      switch_hold_option_q <= 1'b0;
      prdata               <= 32'h00000000;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (wr && pready) begin
        case (idx)
          `ADG_IDX_CELL_THR:   cell_thr_q <= {3'h0, pwdata[4:0]};
          `ADG_IDX_AUX_OPEN_WIRE_LIMIT: aux_ow_q   <= {1'b0, pwdata[6:0]};
          `ADG_IDX_CMP_CTRL:   ctrl_q     <= {1'b0, 1'b0, pwdata[5:1], 1'b0};
          `ADG_IDX_INJ_CTRL:   inj_q      <= {6'h00, pwdata[1:0]};
          `ADG_IDX_PROT_CTRL:  prot_q     <= {7'h00, pwdata[0]};
          `ADG_IDX_SW_SEL:     sw_sel_q   <= {2'h0, pwdata[5:0]};
          `ADG_IDX_BAL_CTRL:   switch_hold_option_q <= pwdata[0];
          `ADG_IDX_CELL_SEL:   cell_sel_q <= {2'h0, pwdata[5:0]};
          default:             ;
        endcase
      end
      if (psel && !penable) begin
        case (idx)
          `ADG_IDX_CELL_THR:   prdata <= {24'h000000, cell_thr_q};
          `ADG_IDX_AUX_OPEN_WIRE_LIMIT: prdata <= {24'h000000, aux_ow_q};
          `ADG_IDX_CMP_CTRL:   prdata <= {24'h000000, ctrl_q[7:1], go_q};
          `ADG_IDX_INJ_CTRL:   prdata <= {24'h000000, inj_q};
          `ADG_IDX_PROT_CTRL:  prdata <= {24'h000000, prot_q};
          `ADG_IDX_SW_SEL:     prdata <= {24'h000000, sw_sel_q};
          `ADG_IDX_STATUS:     prdata <= {24'h000000, filter_failure_flag_q, fault_latch_q,
                                          pass_q, aux_input_check_ready_q,
                                          switch_check_ready_q, balance_pin_open_ready_q,
                                          sense_pin_open_ready_q, cell_check_ready_q};
          `ADG_IDX_BAL_CTRL:   prdata <= {31'h00000000, switch_hold_option_q};
          `ADG_IDX_CELL_SEL:   prdata <= {24'h000000, cell_sel_q};
          default:             prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // adg_diag_compare

// ### adg_diag_props.sv
// Concurrent checks on the diagnostic comparison block ports.
`timescale 1ns/1ps
`include "adc_diag_defs.vh"
module adg_diag_props #(
  parameter N_CH = 6,
  parameter MW   = 16
) (
  input logic            clock,
  input logic            nrst,
  input logic            psel,
  input logic            penable,
  input logic            pwrite,
  input logic [13:0]     paddr,
  input logic [31:0]     pwdata,
  input logic            pready,
  input logic            pslverr,
  input logic            balancing_run,
  input logic [N_CH-1:0] regular_switch,
  input logic [3:0]      selftest_fault_in,
  input logic [N_CH-1:0] balancing_switch,
  input logic            sense_sink_en,
  input logic            balance_sink_en,
  input logic            shunt_source_en,
  input logic            compare_busy,
  input logic            fault_pin_n
);
  logic       wr_ctl;
  logic       go_ok;
  logic [1:0] sink_q;
  logic [2:0] sink_exp;
  assign wr_ctl = psel && penable && pready && pwrite && paddr[13:2] == `ADG_IDX_CMP_CTRL;
  assign go_ok = pwdata[0] && pwdata[3:1] >= `ADG_SEL_CELL && pwdata[3:1] <= `ADG_SEL_AUX_IN;
  assign sink_exp = (sink_q == 2'h0) ? 3'h0 : 3'h1 << (sink_q - 2'h1);
  // Shadow of the written sink code, so the decode is judged two clocks after the write.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) sink_q <= 2'h0;
    else if (wr_ctl) sink_q <= pwdata[5:4];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  a_pready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("pready outside access phase");
  a_slverr_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_sink_decode: assert property (wr_ctl |-> ##2 {shunt_source_en, balance_sink_en, sense_sink_en} == sink_exp) else $error("sink enables wrong");
  a_sink_onehot: assert property ($onehot0({shunt_source_en, balance_sink_en, sense_sink_en})) else $error("two sinks on");
  a_busy_pulse: assert property (compare_busy |=> !compare_busy) else $error("busy too long");
  a_busy_cause: assert property ($rose(compare_busy) |-> $past(wr_ctl && go_ok)) else $error("busy without go");
  a_no_busy: assert property (wr_ctl && !go_ok |=> !compare_busy) else $error("busy on idle code");
  a_fault_pin: assert property (|selftest_fault_in |=> !fault_pin_n) else $error("fault pin idle");
  a_switch_regular: assert property (balancing_run && $past(balancing_run) |-> balancing_switch == $past(regular_switch)) else $error("switch not regular");
  c_busy: cover property (compare_busy);
  c_slverr: cover property (pslverr);
  c_fault: cover property (!fault_pin_n);
endmodule // adg_diag_props

bind adg_diag_compare adg_diag_props #(.N_CH(N_CH), .MW(MW)) props_u (
  .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .balancing_run(balancing_run), .regular_switch(regular_switch),
  .selftest_fault_in(selftest_fault_in), .balancing_switch(balancing_switch),
  .sense_sink_en(sense_sink_en), .balance_sink_en(balance_sink_en),
  .shunt_source_en(shunt_source_en), .compare_busy(compare_busy), .fault_pin_n(fault_pin_n));

// ### adg_diag_tb.sv
// Self-checking testbench for the diagnostic comparison block.
`timescale 1ns/1ps
`include "adc_diag_defs.vh"
module testbench;
  logic        clock = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [13:0] paddr = 14'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, bal_run = 1'b0, bal_start = 1'b0, step = 1'b0;
  logic [95:0] main_mv = 96'h0, aux_mv = 96'h0;
  logic [5:0]  reg_sw = 6'h00, bal_sw;
  logic [3:0]  st_in = 4'h0, st_q;
  logic        snk_s, snk_b, src_sh, busy, fpin_n;
  logic [7:0]  rw_v [5] = '{8'h1F, 8'h7F, 8'h00, 8'h03, 8'h01};
  logic [2:0]  t_sel [9] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h5, 3'h5, 3'h5, 3'h5};
  logic [7:0]  t_thr [9] = '{8'h00, 8'h00, 8'h1F, 8'h1F, 8'h0A, 8'h00, 8'h00, 8'h70, 8'h70};
  logic [15:0] t_dl [9] = '{16'h5, 16'h6, 16'h62, 16'h63, 16'h23, 16'h3, 16'h4, 16'h1F, 16'h20};
  int          err_total = 0, checked = 0, cyc = 0, lim;
  always #4 clock = ~clock;
  // A hang counts as a mismatch and still reaches the verdict.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  adg_diag_compare #(.N_CH(6), .MW(16)) dut_u (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_mv(main_mv), .aux_mv(aux_mv), .active_cell(6'h3F), .aux_is_analog(6'h3F),
    .balancing_run(bal_run), .balancing_start(bal_start), .regular_switch(reg_sw),
    .filter_test_fault(1'b0), .selftest_channel_step(step), .selftest_fault_in(st_in),
    .balancing_switch(bal_sw), .sense_sink_en(snk_s), .balance_sink_en(snk_b),
    .shunt_source_en(src_sh), .compare_busy(busy), .selftest_fault_q(st_q),
    .fault_pin_n(fpin_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Values sampled right after the edge are those the edge itself saw.
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] idx, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0);
    chk(rd & m, e);
  endtask
  // Open-wire runs carry their own sink code; the sink enable rises at the edge that ends the check.
  task automatic run_cmp(input logic [2:0] sel);
    logic [1:0] snk;
    snk = (sel == 3'h2) ? 2'h1 : (sel == 3'h3) ? 2'h2 : 2'h0;
    xfer(1'b1, `ADG_IDX_CMP_CTRL, {26'h0, snk, sel, 1'b1});
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rchk(`ADG_IDX_CELL_THR + i, 32'hFFFFFFFF, 32'h0);
      xfer(1'b1, `ADG_IDX_CELL_THR + i, {24'h0, rw_v[i]});
      rchk(`ADG_IDX_CELL_THR + i, 32'hFFFFFFFF, {24'h0, rw_v[i]});
      xfer(1'b1, `ADG_IDX_CELL_THR + i, 32'h0);
    end
    // The injection write above raised the filter flag; clear it before status checks.
    xfer(1'b1, `ADG_IDX_STATUS, 32'h80);
    xfer(1'b0, 12'h100, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    $display("test registers done");
    main_mv <= {6{16'h03E8}};
    aux_mv <= {6{16'h03E8}};
    xfer(1'b1, `ADG_IDX_CELL_SEL, 32'h1);
    xfer(1'b1, `ADG_IDX_BAL_CTRL, 32'h0);
    for (int c = 1; c < 6; c++) begin
      run_cmp(c[2:0]);
      rchk(`ADG_IDX_STATUS, 32'h1F, 32'h1 << (c - 1));
    end
    for (int i = 0; i < 9; i++) begin
      xfer(1'b1, t_sel[i] == 3'h1 ? `ADG_IDX_CELL_THR : `ADG_IDX_AUX_OPEN_WIRE_LIMIT, {24'h0, t_thr[i]});
      main_mv[15:0] <= 16'h03E8 + t_dl[i];
      lim = t_sel[i] == 3'h1 ? 6 + 3 * t_thr[i] : 4 + 4 * t_thr[i][6:4];
      if (lim > 99) lim = 99;
      run_cmp(t_sel[i]);
      rchk(`ADG_IDX_STATUS, 32'hFF, (t_dl[i] < lim ? 32'h20 : 32'h0) | 32'h1 << (t_sel[i] - 1));
    end
    main_mv[15:0] <= 16'h03E8;
    xfer(1'b1, `ADG_IDX_INJ_CTRL, 32'h2);
    run_cmp(3'h1);
    rchk(`ADG_IDX_STATUS, 32'hFF, 32'h01);
    xfer(1'b1, `ADG_IDX_INJ_CTRL, 32'h0);
    run_cmp(3'h1);
    rchk(`ADG_IDX_CMP_CTRL, 32'hFF, 32'h03);
    rchk(`ADG_IDX_CMP_CTRL, 32'hFF, 32'h02);
    xfer(1'b1, `ADG_IDX_CMP_CTRL, 32'h0A);
    rchk(`ADG_IDX_STATUS, 32'hFF, 32'h21);
    $display("test comparisons done");
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, `ADG_IDX_CMP_CTRL, s << 4);
      repeat (2) @(posedge clock);
      chk({29'h0, src_sh, snk_b, snk_s}, s == 0 ? 32'h0 : 32'h1 << (s - 1));
    end
    xfer(1'b1, `ADG_IDX_SW_SEL, 32'h15);
    xfer(1'b1, `ADG_IDX_CMP_CTRL, 32'h40);
    repeat (2) @(posedge clock);
    chk({26'h0, bal_sw}, 32'h15);
    reg_sw <= 6'h2A;
    bal_run <= 1'b1;
    bal_start <= 1'b1;
    @(posedge clock);
    bal_start <= 1'b0;
    repeat (2) @(posedge clock);
    chk({26'h0, bal_sw}, 32'h2A);
    xfer(1'b1, `ADG_IDX_CMP_CTRL, 32'h40);
    repeat (2) @(posedge clock);
    chk({26'h0, bal_sw}, 32'h2A);
    bal_run <= 1'b0;
    $display("test switches done");
    xfer(1'b1, `ADG_IDX_INJ_CTRL, 32'h1);
    rchk(`ADG_IDX_STATUS, 32'h80, 32'h80);
    xfer(1'b1, `ADG_IDX_INJ_CTRL, 32'h0);
    xfer(1'b1, `ADG_IDX_STATUS, 32'h80);
    rchk(`ADG_IDX_STATUS, 32'hC0, 32'h0);
    xfer(1'b1, `ADG_IDX_PROT_CTRL, 32'h1);
    st_in <= 4'h1;
    @(posedge clock);
    st_in <= 4'h0;
    step <= 1'b1;
    @(posedge clock);
    step <= 1'b0;
    repeat (2) @(posedge clock);
    chk({27'h0, st_q, fpin_n}, 32'h02);
    xfer(1'b1, `ADG_IDX_PROT_CTRL, 32'h0);
    step <= 1'b1;
    @(posedge clock);
    step <= 1'b0;
    repeat (2) @(posedge clock);
    chk({27'h0, st_q, fpin_n}, 32'h01);
    $display("test faults done");
    finish_test();
  end
endmodule // testbench
